// >>> hw/fpc_front_panel.sv
// Front panel controller: display refresh, keyboard encoder, rotary
// counter, power-on fallback and display self-test.
// Assumes clk, nrst and the bus strobes are in one domain; panel
// switches and encoder phases are asynchronous and synchronised here.
`timescale 1ns/1ps
module fpc_front_panel
    import fpc_pkg::*;
#(
    parameter longint MSG_CYC = FPC_MSG_CYC,
    parameter longint FLASH_CYC = FPC_FLASH_CYC,
    parameter longint POWERON_CYC = FPC_POWERON_CYC,
    parameter longint BLINK_CYC = FPC_BLINK_CYC,
    parameter longint SCROLL_CYC = FPC_SCROLL_CYC,
    parameter longint COL_CYC = FPC_COL_CYC,
    parameter longint DEBOUNCE_CYC = FPC_DEBOUNCE_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instrument bus
    input wire fpc_pkg::fpc_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    output logic key_srq,
    output logic rot_srq,
    // Panel inputs
    input wire logic [fpc_pkg::FPC_KEY_COLS-1:0] key_col_n,
    input wire logic [fpc_pkg::FPC_KEY_ROWS-1:0] key_row_n,
    input wire logic instrument_preset_key_n,
    input wire logic rotary_encoder_a,
    input wire logic rotary_encoder_b,
    // Displays
    output fpc_pkg::fpc_alpha_drive_type alpha_drive,
    output logic [fpc_pkg::FPC_SEG_DIGITS*7-1:0] seg_drive,
    output logic [fpc_pkg::FPC_LEDS-1:0] led_drive,
    output logic diag_active
);
    import fpc_pkg::*;

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic [2:0] onehot_index(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Column pattern of a character; glyphs are synthetic bit mixes of the code
    function automatic logic [6:0] glyph_col(input logic [7:0] ch, input logic [2:0] col);
        logic [7:0] m;
        m = ch ^ {ch[4:0], col};
        return (ch == 8'h20) ? 7'h00 : m[6:0];
    endfunction

    // Seven-segment pattern of the low nibble as a digit, blank for nibbles above 9
    function automatic logic [6:0] seg_of(input logic [7:0] d);
        logic [6:0] s;
        case (d[3:0])
            4'h0: s = 7'h3f;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;
            default: s = 7'h00;
        endcase
        return s;
    endfunction

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    localparam int SW = FPC_KEY_COLS + FPC_KEY_ROWS + 3;
    logic [SW-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end
        else
        begin
            sync1_reg <= {key_col_n, key_row_n, instrument_preset_key_n,
                rotary_encoder_a, rotary_encoder_b};
            sync2_reg <= sync1_reg;
        end
    end
    logic [7:0] kcol, krow;
    logic preset_held, enc_a, enc_b;
    assign kcol = ~sync2_reg[SW-1 -: 8];
    assign krow = ~sync2_reg[SW-9 -: 8];
    assign preset_held = ~sync2_reg[2];
    assign enc_a = sync2_reg[1];
    assign enc_b = sync2_reg[0];

    // ********************************************************
    // Display RAM and bus writes
    // ********************************************************
    logic [7:0] alpha_ram [FPC_CHARS];
    logic [7:0] seg_ram [FPC_SEG_DIGITS];
    logic [FPC_LEDS-1:0] led_reg;
    logic wrote_reg;
    logic wr_alpha, wr_seg, wr_led;
    assign wr_alpha = bus_req.wr && bus_req.addr < FPC_ADDR_ALPHA + 8'(FPC_CHARS);
    assign wr_seg = bus_req.wr && bus_req.addr >= FPC_ADDR_SEG
        && bus_req.addr < FPC_ADDR_SEG + 8'(FPC_SEG_DIGITS);
    assign wr_led = bus_req.wr && bus_req.addr >= FPC_ADDR_LED
        && bus_req.addr < FPC_ADDR_LED + FPC_LED_BYTES;

    // RAM arrays carry no reset; content is undefined until written
    always_ff @(posedge clk)
    begin
        if (wr_alpha)
        begin
            alpha_ram[bus_req.addr[4:0]] <= bus_req.wdata;
        end
        if (wr_seg)
        begin
            seg_ram[bus_req.addr[3:0]] <= bus_req.wdata;
        end
    end

    logic [FPC_LEDS-1:0] led_next;
    always_comb
    begin
        led_next = led_reg;
        if (wr_led)
        begin
            led_next[{bus_req.addr[1:0], 3'h0} +: 8] = bus_req.wdata;
        end
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            led_reg <= '0;
            wrote_reg <= 1'b0;
        end
        else
        begin
            led_reg <= led_next;
            wrote_reg <= wrote_reg | bus_req.wr;
        end
    end

    // ********************************************************
    // Keyboard encoder
    // ********************************************************
    logic [5:0] key_reg, key_next, last_key_next;
    logic key_srq_reg, key_srq_next, armed_reg, armed_next, pressed;
    logic [31:0] deb_reg, deb_next;
    logic key_read, key_event;
    assign pressed = (|kcol) && (|krow);
    assign key_read = bus_req.rd && bus_req.addr == FPC_ADDR_KEY;
    always_comb
    begin
        key_next = key_reg;
        key_srq_next = key_srq_reg;
        armed_next = armed_reg;
        deb_next = deb_reg;
        key_event = 1'b0;
        last_key_next = FPC_KEY_NONE;
        if (!pressed)
        begin
            deb_next = '0;
            armed_next = 1'b1;
        end
        else if (armed_reg && deb_reg < 32'(DEBOUNCE_CYC))
        begin
            deb_next = deb_reg + 32'h1;
        end
        else if (armed_reg)
        begin
            armed_next = 1'b0;
            key_event = 1'b1;
            last_key_next = {onehot_index(kcol), onehot_index(krow)};
        end
        if (key_read)
        begin
            key_srq_next = 1'b0;
        end
        // New key only replaces an unread one once it has been read
        if (key_event && (!key_srq_reg || key_read))
        begin
            key_next = last_key_next;
            key_srq_next = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_reg <= FPC_KEY_NONE;
            key_srq_reg <= 1'b0;
            armed_reg <= 1'b1;
            deb_reg <= '0;
        end
        else
        begin
            key_reg <= key_next;
            key_srq_reg <= key_srq_next;
            armed_reg <= armed_next;
            deb_reg <= deb_next;
        end
    end

    // ********************************************************
    // Rotary step counter
    // ********************************************************
    logic [7:0] rot_reg, rot_next;
    logic rot_srq_reg, rot_srq_next, a_prev_reg;
    always_comb
    begin
        rot_next = rot_reg;
        rot_srq_next = rot_srq_reg;
        if (bus_req.rd && bus_req.addr == FPC_ADDR_ROT)
        begin
            rot_srq_next = 1'b0;
        end
        if (enc_a && !a_prev_reg)
        begin
            rot_next = enc_b ? rot_reg - 8'h1 : rot_reg + 8'h1;
            rot_srq_next = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rot_reg <= '0;
            rot_srq_reg <= 1'b0;
            a_prev_reg <= 1'b1;
        end
        else
        begin
            rot_reg <= rot_next;
            rot_srq_reg <= rot_srq_next;
            a_prev_reg <= enc_a;
        end
    end

    // ********************************************************
    // Mode sequencer
    // ********************************************************
    fpc_mode_type mode_reg, mode_next;
    logic [31:0] tmr_reg, tmr_next;
    logic shift_seen_reg, shift_seen_next;
    always_comb
    begin
        mode_next = mode_reg;
        tmr_next = tmr_reg + 32'h1;
        shift_seen_next = shift_seen_reg;
        if (key_event)
        begin
            shift_seen_next = last_key_next == FPC_KEY_SHIFT;
        end
        case (mode_reg)
            FPC_POWERON:
            begin
                if (wrote_reg || preset_held)
                begin
                    mode_next = FPC_NORMAL;
                end
                else if (tmr_reg >= 32'(POWERON_CYC))
                begin
                    mode_next = FPC_DIAG_RAM;
                    tmr_next = '0;
                end
            end
            FPC_NORMAL:
            begin
                if (key_event && shift_seen_reg && last_key_next == FPC_KEY_FREE_RUN)
                begin
                    mode_next = FPC_DIAG_RAM;
                    tmr_next = '0;
                end
            end
            FPC_DIAG_RAM, FPC_DIAG_SUM:
            begin
                if (tmr_reg >= 32'(MSG_CYC - 1))
                begin
                    mode_next = mode_reg == FPC_DIAG_RAM
                        ? FPC_DIAG_SUM : FPC_DIAG_FLASH;
                    tmr_next = '0;
                end
            end
            FPC_DIAG_FLASH:
            begin
                if (tmr_reg >= 32'(FLASH_CYC - 1))
                begin
                    mode_next = FPC_DIAG_SCROLL;
                    tmr_next = '0;
                end
            end
            FPC_DIAG_SCROLL:
            begin
                if (tmr_reg >= 32'(SCROLL_CYC - 1))
                begin
                    tmr_next = '0;
                end
            end
            default: mode_next = FPC_NORMAL;
        endcase
        if (mode_reg >= FPC_DIAG_RAM && key_event && shift_seen_reg
            && last_key_next == FPC_KEY_MENU5)
        begin
            mode_next = FPC_NORMAL;
        end
    end
    logic [7:0] scroll_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_reg <= FPC_POWERON;
            tmr_reg <= '0;
            shift_seen_reg <= 1'b0;
            scroll_reg <= 8'h20;
        end
        else
        begin
            mode_reg <= mode_next;
            tmr_reg <= tmr_next;
            shift_seen_reg <= shift_seen_next;
            if (mode_reg == FPC_DIAG_SCROLL && tmr_next == '0)
            begin
                scroll_reg <= scroll_reg == 8'h7e ? 8'h20 : scroll_reg + 8'h1;
            end
        end
    end

    // ********************************************************
    // Refresh scan and display drive
    // ********************************************************
    logic [31:0] col_tmr_reg;
    logic [2:0] col_reg;
    logic [31:0] blink_reg;
    logic blink_on_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            col_tmr_reg <= '0;
            col_reg <= '0;
            blink_reg <= '0;
            blink_on_reg <= 1'b1;
        end
        else
        begin
            col_tmr_reg <= col_tmr_reg >= 32'(COL_CYC - 1) ? '0 : col_tmr_reg + 32'h1;
            if (col_tmr_reg >= 32'(COL_CYC - 1))
            begin
                col_reg <= col_reg == 3'(FPC_COLS - 1) ? 3'h0 : col_reg + 3'h1;
            end
            blink_reg <= blink_reg >= 32'(BLINK_CYC - 1) ? '0 : blink_reg + 32'h1;
            if (blink_reg >= 32'(BLINK_CYC - 1))
            begin
                blink_on_reg <= ~blink_on_reg;
            end
        end
    end

    // Message text is synthetic: digits of the checksum and a fill code
    function automatic logic [7:0] char_at(input int i);
        logic [7:0] c;
        case (mode_reg)
            FPC_DIAG_RAM: c = 8'h50;
            FPC_DIAG_SUM: c = (i == 0) ? {4'h3, FPC_CHECKSUM[7:4]}
                : (i == 1) ? 8'h41 : 8'h20;
            FPC_DIAG_SCROLL: c = 8'(scroll_reg + 8'(i));
            default: c = alpha_ram[i];
        endcase
        return c;
    endfunction

    // 196-dot column is built per column slot, but only character 0's 7 dots reach row_data
    logic [FPC_CHARS*FPC_ROWS-1:0] col_bits;
    always_comb
    begin
        col_bits = '0;
        for (int i = 0; i < FPC_CHARS; i++)
        begin
            col_bits[i*FPC_ROWS +: FPC_ROWS] = (mode_reg == FPC_DIAG_FLASH)
                ? {FPC_ROWS{blink_on_reg}}
                : glyph_col(char_at(i), col_reg);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            alpha_drive <= '0;
            seg_drive <= '0;
            led_drive <= '0;
            bus_rdata <= '0;
        end
        else
        begin
            alpha_drive.col <= FPC_COLS'(1) << col_reg;
            alpha_drive.row_data <= col_bits[FPC_ROWS-1:0];
            alpha_drive.row_load <= col_tmr_reg == '0;
            for (int d = 0; d < FPC_SEG_DIGITS; d++)
            begin
                seg_drive[d*7 +: 7] <= mode_reg == FPC_DIAG_FLASH ? 7'h7f
                    : mode_reg == FPC_DIAG_SCROLL ? seg_of(8'(scroll_reg + 8'(d)))
                    : seg_of(seg_ram[d]);
            end
            led_drive <= preset_held ? '1 : led_reg;
            case (bus_req.addr)
                FPC_ADDR_KEY: bus_rdata <= {2'h0, key_reg};
                FPC_ADDR_ROT: bus_rdata <= rot_reg;
                FPC_ADDR_STAT: bus_rdata <= {5'h0, 3'(mode_reg)};
                default: bus_rdata <= 8'h00;
            endcase
        end
    end

    assign key_srq = key_srq_reg;
    assign rot_srq = rot_srq_reg;
    assign diag_active = mode_reg >= FPC_DIAG_RAM;
endmodule

// >>> hw/fpc_pkg.sv
// Package for the front panel controller: constants, states and carriers.
// Assumes a single 20 MHz clock domain shared by all users of the package.
package fpc_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int FPC_CHARS = 28;
    localparam int FPC_COLS = 5;
    localparam int FPC_ROWS = 7;
    localparam int FPC_SEG_DIGITS = 16;
    localparam int FPC_LEDS = 32;
    localparam int FPC_KEY_COLS = 8;
    localparam int FPC_KEY_ROWS = 8;

    // ********************************************************
    // Bus map (byte addresses on the instrument address bus)
    // ********************************************************
    localparam logic [7:0] FPC_ADDR_ALPHA = 8'h00;
    localparam logic [7:0] FPC_ADDR_SEG = 8'h20;
    localparam logic [7:0] FPC_ADDR_LED = 8'h30;
    localparam logic [7:0] FPC_ADDR_KEY = 8'h40;
    localparam logic [7:0] FPC_ADDR_ROT = 8'h41;
    localparam logic [7:0] FPC_ADDR_STAT = 8'h42;
    localparam logic [7:0] FPC_LED_BYTES = 8'h04;
    localparam logic [7:0] FPC_CHECKSUM = 8'h3a;

    // ********************************************************
    // Key codes
    // ********************************************************
    localparam logic [5:0] FPC_KEY_SHIFT = 6'h00;
    localparam logic [5:0] FPC_KEY_FREE_RUN = 6'h01;
    localparam logic [5:0] FPC_KEY_MENU5 = 6'h02;
    localparam logic [5:0] FPC_KEY_NONE = 6'h3f;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam longint FPC_CLK_HZ = 20000000;
    localparam longint FPC_REFRESH_HZ = 80;
    localparam longint FPC_MSG_S = 3;
    localparam longint FPC_FLASH_S = 6;
    localparam longint FPC_POWERON_MS = 500;
    localparam longint FPC_FLASH_HZ = 2;
    localparam longint FPC_SCROLL_HZ = 4;
    localparam longint FPC_DEBOUNCE_US = 5000;
    localparam longint FPC_COL_CYC = FPC_CLK_HZ / (FPC_REFRESH_HZ * FPC_COLS);
    localparam longint FPC_MSG_CYC = FPC_MSG_S * FPC_CLK_HZ;
    localparam longint FPC_FLASH_CYC = FPC_FLASH_S * FPC_CLK_HZ;
    localparam longint FPC_POWERON_CYC = FPC_POWERON_MS * FPC_CLK_HZ / 1000;
    localparam longint FPC_BLINK_CYC = FPC_CLK_HZ / (2 * FPC_FLASH_HZ);
    localparam longint FPC_SCROLL_CYC = FPC_CLK_HZ / FPC_SCROLL_HZ;
    localparam longint FPC_DEBOUNCE_CYC = (FPC_DEBOUNCE_US * FPC_CLK_HZ + 999999) / 1000000;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        FPC_POWERON,
        FPC_NORMAL,
        FPC_DIAG_RAM,
        FPC_DIAG_SUM,
        FPC_DIAG_FLASH,
        FPC_DIAG_SCROLL
    } fpc_mode_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpc_bus_req_type;

    typedef struct packed {
        logic [FPC_COLS-1:0] col;
        logic [FPC_ROWS-1:0] row_data;
        logic row_load;
    } fpc_alpha_drive_type;

endpackage

// >>> verif/fpc_cpu_model.sv
// Model of the main instrument processor on the instrument buses.
// Assumes the bench calls one task at a time; requests launch at an edge.
`timescale 1ns/1ps
module fpc_cpu_model
    import fpc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Instrument bus
    output fpc_pkg::fpc_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata
);
    initial
    begin
        bus_req = '0;
    end

    // Data inverted after the strobe so stale bytes never look valid
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        bus_req.wdata <= ~d;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic watch(input logic [7:0] a);
        @(posedge clk);
        bus_req.addr <= a;
    endtask
endmodule

// >>> verif/fpc_front_panel_monitor.sv
// Checker for the front panel controller, bound to its top module.
// Assumes one clock domain; sees only the controller's ports.
`timescale 1ns/1ps
module fpc_front_panel_monitor
    import fpc_pkg::*;
#(
    parameter longint POWERON_CYC = 50,
    parameter longint COL_CYC = 10
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instrument bus
    input wire fpc_pkg::fpc_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic key_srq,
    input wire logic rot_srq,
    // Panel and displays
    input wire logic instrument_preset_key_n,
    input wire fpc_pkg::fpc_alpha_drive_type alpha_drive,
    input wire logic [fpc_pkg::FPC_LEDS-1:0] led_drive,
    input wire logic diag_active
);
    // ****************
    // Helper counters
    // ****************
    logic [15:0] gap_reg;
    logic [15:0] gap_next;
    logic [15:0] age_reg;
    logic [15:0] age_next;
    logic seen_reg;
    logic seen_next;
    logic quiet_reg;
    logic quiet_next;

    always_comb
    begin
        gap_next = alpha_drive.row_load ? 16'h1 : gap_reg + 16'h1;
        seen_next = seen_reg | alpha_drive.row_load;
        age_next = (age_reg == 16'hffff) ? age_reg : age_reg + 16'h1;
        // Raw preset is conservative: any low sample cancels
        quiet_next = quiet_reg & ~bus_req.wr & instrument_preset_key_n;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_reg <= 16'h0;
            age_reg <= 16'h0;
            seen_reg <= 1'b0;
            quiet_reg <= 1'b1;
        end
        else
        begin
            gap_reg <= gap_next;
            age_reg <= age_next;
            seen_reg <= seen_next;
            quiet_reg <= quiet_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ****************
    // Assertions
    // ****************
    AST_REFRESH_SLOT: assert property (alpha_drive.row_load && seen_reg |->
        gap_reg == COL_CYC)
        else $error("column slot length wrong");
    AST_COL_ONEHOT: assert property (alpha_drive.row_load |->
        $onehot(alpha_drive.col))
        else $error("column select not one-hot");
    AST_COL_STEADY: assert property (alpha_drive.row_load |=>
        ##1 $stable(alpha_drive.col)[*7])
        else $error("column moved within its slot");
    AST_PRESET_LEDS: assert property ((!instrument_preset_key_n)[*4] |-> &led_drive)
        else $error("leds not all lit under preset");
    AST_KEY_HELD: assert property ($fell(key_srq) |->
        $past(bus_req.rd) && $past(bus_req.addr) == FPC_ADDR_KEY)
        else $error("key request dropped without a read");
    AST_ROT_HELD: assert property ($fell(rot_srq) |->
        $past(bus_req.rd) && $past(bus_req.addr) == FPC_ADDR_ROT)
        else $error("rotary request dropped without a read");
    AST_POWERON_DIAG: assert property (quiet_reg && age_reg == POWERON_CYC + 4 |->
        diag_active)
        else $error("no fallback to diagnostic");
    AST_MODE_VIEW: assert property (bus_req.addr == FPC_ADDR_STAT |=>
        (bus_rdata >= 8'h02) == $past(diag_active))
        else $error("mode byte disagrees with diagnostic flag");

    COV_ROW_LOAD: cover property (alpha_drive.row_load);
    COV_KEY: cover property ($rose(key_srq));
    COV_DIAG: cover property ($rose(diag_active));
endmodule

// >>> verif/fpc_tb.sv
// Bench for the front panel controller with a processor model.
// Assumes shortened counts so the diagnostic phases fit a short run.
`timescale 1ns/1ps
module tb;
    import fpc_pkg::*;
    localparam longint MSG = 60;
    localparam longint FLASH = 120;
    localparam longint PON = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    fpc_bus_req_type bus_req;
    logic [7:0] bus_rdata;
    logic key_srq;
    logic rot_srq;
    logic [7:0] key_col_n = 8'hff;
    logic [7:0] key_row_n = 8'hff;
    logic preset_n = 1'b1;
    logic rot_a = 1'b0;
    logic rot_b = 1'b0;
    fpc_alpha_drive_type alpha_drive;
    logic [111:0] seg_drive;
    logic [31:0] led_drive;
    logic diag_active;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    logic [7:0] rd;
    // Rows: address, data, expected LED byte, segment digit or column dots
    logic [23:0] rows [10] = '{24'h30a5a5, 24'h313c3c, 24'h320000, 24'h33ffff,
        24'h20087f, 24'h210106, 24'h220a00, 24'h23003f, 24'h2f0707, 24'h002000};

    always #25 clk = ~clk;

    fpc_cpu_model i_cpu (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

    fpc_front_panel #(.MSG_CYC(MSG), .FLASH_CYC(FLASH), .POWERON_CYC(PON), .BLINK_CYC(4),
        .SCROLL_CYC(8), .COL_CYC(10), .DEBOUNCE_CYC(2)) i_dut (.clk(clk), .nrst(nrst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .key_srq(key_srq), .rot_srq(rot_srq),
        .key_col_n(key_col_n), .key_row_n(key_row_n), .instrument_preset_key_n(preset_n),
        .rotary_encoder_a(rot_a), .rotary_encoder_b(rot_b), .alpha_drive(alpha_drive),
        .seg_drive(seg_drive), .led_drive(led_drive), .diag_active(diag_active));

    // ****************
    // Tasks
    // ****************
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Held past synchroniser and debounce, then released
    task automatic press(input int c, input int r);
        @(posedge clk);
        key_col_n <= ~(8'h01 << c);
        key_row_n <= ~(8'h01 << r);
        tick(8);
        @(posedge clk);
        key_col_n <= 8'hff;
        key_row_n <= 8'hff;
        tick(8);
    endtask

    task automatic step(input logic dn);
        @(posedge clk);
        rot_b <= dn;
        tick(3);
        @(posedge clk);
        rot_a <= 1'b1;
        tick(6);
        @(posedge clk);
        rot_a <= 1'b0;
        tick(6);
    endtask

    // Polls the mode byte each cycle, so n has one cycle of slack
    task automatic phase(input logic [7:0] m, input longint lo, input longint hi);
        n = 0;
        while (bus_rdata !== m && n < hi + 2)
        begin
            tick(1);
            n++;
        end
        check_word(32'(bus_rdata), 32'(m));
        check_bit(n >= lo && n <= hi, 1'b1);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    // ****************
    // Sequence
    // ****************
    initial
    begin
        tick(10);
        check_bit(key_srq | rot_srq | diag_active | (|led_drive), 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        i_cpu.write(FPC_ADDR_LED, 8'h00);
        foreach (rows[i])
        begin
            i_cpu.write(rows[i][23:16], rows[i][15:8]);
            tick(2);
            if (rows[i][21:20] == 2'h3)
                check_word(32'(led_drive[rows[i][17:16]*8 +: 8]), 32'(rows[i][7:0]));
            else if (rows[i][21:20] == 2'h0)
                check_word(32'(alpha_drive.row_data), 32'(rows[i][7:0]));
            else
                check_word(32'(seg_drive[rows[i][19:16]*7 +: 7]), 32'(rows[i][7:0]));
        end
        tick(PON);
        check_bit(diag_active, 1'b0);
        i_cpu.read(8'h50, rd);
        check_word(32'(rd), 32'h0);
        @(posedge clk);
        preset_n <= 1'b0;
        tick(6);
        check_word(led_drive, 32'hffffffff);
        @(posedge clk);
        preset_n <= 1'b1;
        tick(6);
        check_word(led_drive, 32'hff003ca5);
        press(2, 3);
        check_bit(key_srq, 1'b1);
        press(4, 5);
        i_cpu.read(FPC_ADDR_KEY, rd);
        check_word(32'(rd), 32'h13);
        check_bit(key_srq, 1'b0);
        for (int i = 0; i < 4; i++)
            step(i == 3);
        check_bit(rot_srq, 1'b1);
        i_cpu.read(FPC_ADDR_ROT, rd);
        check_word(32'(rd), 32'h02);
        check_bit(rot_srq, 1'b0);
        for (int i = 0; i < 3; i++)
            step(1'b1);
        i_cpu.read(FPC_ADDR_ROT, rd);
        check_word(32'(rd), 32'hff);
        press(0, 0);
        i_cpu.read(FPC_ADDR_KEY, rd);
        press(0, 1);
        i_cpu.read(FPC_ADDR_KEY, rd);
        i_cpu.watch(FPC_ADDR_STAT);
        phase(8'h02, 0, 40);
        phase(8'h03, 1, MSG);
        phase(8'h04, MSG - 2, MSG + 2);
        tick(2);
        check_bit(&seg_drive, 1'b1);
        check_bit(&alpha_drive.row_data | ~|alpha_drive.row_data, 1'b1);
        phase(8'h05, FLASH - 5, FLASH + 2);
        tick(24);
        check_word(32'(bus_rdata), 32'h05);
        press(0, 0);
        i_cpu.read(FPC_ADDR_KEY, rd);
        press(0, 2);
        i_cpu.read(FPC_ADDR_KEY, rd);
        tick(4);
        check_bit(diag_active, 1'b0);
        // Second power-up with no write: must fall back to self-test
        @(posedge clk);
        nrst <= 1'b0;
        tick(3);
        @(posedge clk);
        nrst <= 1'b1;
        tick(PON + 6);
        check_bit(diag_active, 1'b1);
        @(posedge clk);
        nrst <= 1'b0;
        preset_n <= 1'b0;
        tick(3);
        @(posedge clk);
        nrst <= 1'b1;
        tick(PON + 6);
        check_bit(diag_active, 1'b0);
        check_word(led_drive, 32'hffffffff);
        close_out();
    end
endmodule

bind fpc_front_panel fpc_front_panel_monitor #(.POWERON_CYC(POWERON_CYC), .COL_CYC(COL_CYC))
    i_mon (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .key_srq(key_srq), .rot_srq(rot_srq), .instrument_preset_key_n(instrument_preset_key_n),
    .alpha_drive(alpha_drive), .led_drive(led_drive), .diag_active(diag_active));
